// [shared/ssi_image_map.svh]
// Offsets, field positions, reset values and timing counts of the
// encoder process image and of the controller's software registers.
// Assumes inclusion by bare name from both ends and the bench.
`ifndef SSI_IMAGE_MAP_SVH
`define SSI_IMAGE_MAP_SVH

// ----------------------------------------------------------------------
// Process image offsets (byte addresses within the two consistent words)
// ----------------------------------------------------------------------
`define IMG_POSITION_OFS 8'h00
`define IMG_STATUS_OFS 8'h04
`define IMG_LOADFLAGS_OFS 8'h05
`define IMG_SPARE_OFS 8'h06

// ----------------------------------------------------------------------
// Feedback word 0 and word 1 field positions
// ----------------------------------------------------------------------
`define FB_FROZEN_BIT 31
`define FB_HEARTBEAT_BIT 7
`define FB_READY_BIT 6
`define FB_CONFIG_FAULT_BIT 5
`define FB_FRAME_FAULT_BIT 4
`define FB_SUPPLY_FAULT_BIT 3
`define FB_INPUT_LEVEL_BIT 2
`define FB_DOWN_BIT 1
`define FB_UP_BIT 0
`define FB_HIT_TWO_BIT 11
`define FB_HIT_ONE_BIT 10
`define FB_LOAD_ERROR_BIT 9
`define FB_LOAD_BUSY_BIT 8

// ----------------------------------------------------------------------
// Control word 1 field positions
// ----------------------------------------------------------------------
`define CTL_FAULT_ACK_BIT 7
`define CTL_LATCH_ACK_BIT 6
`define CTL_LOAD_TWO_BIT 1
`define CTL_LOAD_ONE_BIT 0
`define CTL_USED_MASK 32'h0000_00C3

// ----------------------------------------------------------------------
// Controller software registers on APB
// ----------------------------------------------------------------------
`define REG_CMP_VALUE 8'h00
`define REG_CONTROL 8'h04
`define REG_FB_POSITION 8'h08
`define REG_FB_STATUS 8'h0C
`define REG_FB_COUNT 8'h10

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define WORD_RESET 32'h0000_0000
`define CLK_PERIOD_NS 40
`define CYCLE_TIME_NS 500000
`define CYCLE_CLKS_DEFAULT (`CYCLE_TIME_NS / `CLK_PERIOD_NS)

`endif

// [shared/ssi_image_pkg.sv]
// Types shared by the device end and the controller end of the
// encoder process image. Assumes the map header is on the include path.
package ssi_image_pkg;

    // ------------------------------------------------------------------
    // Load handshake states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        LD_IDLE = 3'b001,
        LD_BUSY = 3'b010,
        LD_ERR = 3'b100
    } load_state_t;

    typedef logic [23:0] cycle_cnt_t;

    // ------------------------------------------------------------------
    // Device end state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] aux_sync;
        logic [1:0] short_sync;
        cycle_cnt_t tick_cnt;
        logic [5:0] red_cnt;
        logic [30:0] pos;
        logic frozen;
        logic heartbeat_toggle;
        logic moving_up_flag;
        logic moving_down_flag;
        logic config_fault;
        logic params_seen;
        logic ready;
        logic encoder_frame_fault;
        logic supply_short_fault;
        logic [31:0] cmp_one;
        logic [31:0] cmp_two;
        logic compare_one_hit;
        logic compare_two_hit;
        load_state_t ld;
        logic load_error;
        logic value_load_busy;
        logic latch_ack;
        logic [31:0] fb_lo;
        logic [31:0] fb_hi;
        logic fb_valid;
    } dev_state_t;

    // ------------------------------------------------------------------
    // Controller end state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [31:0] stage_val;
        logic [31:0] ctl_lo;
        logic [31:0] ctl_hi;
        logic [31:0] fb_lo;
        logic [31:0] fb_hi;
        logic [7:0] fb_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mst_state_t;

endpackage

// [shared/ssi_image_if.sv]
// Cyclic process image between the encoder module and its controller.
// Assumes both ends run on the same clock; each word is one consistent
// unit and a feedback update is marked by a one-cycle strobe.
`timescale 1ns/1ns
`default_nettype none
interface ssi_image_if;
    logic [31:0] fb_lo;
    logic [31:0] fb_hi;
    logic fb_valid;
    logic [31:0] ctl_lo;
    logic [31:0] ctl_hi;

    modport device
    (
        output fb_lo,
        output fb_hi,
        output fb_valid,
        input ctl_lo,
        input ctl_hi
    );

    modport master
    (
        input fb_lo,
        input fb_hi,
        input fb_valid,
        output ctl_lo,
        output ctl_hi
    );
endinterface
`default_nettype wire

// [rtl/image_device_end.sv]
// Device end of the encoder process image: builds the feedback words once
// per processing cycle and acts on the control words.
// Assumes encoder results come from same-clock receiver logic; the two
// pins aux_input_pin_i and supply_short_i are asynchronous.
//
// Notes on behaviour
// - Each feedback word changes whole, never partly.
// - Word 0 is position; bit 31 marks frozen.
// - Byte 4 holds heartbeat, ready, faults, input, direction.
// - Byte 5 holds hits, load error, busy; rest zero.
// - Controller writes comparison value into control word 0.
// - Control byte 4: ack, latch ack, two loads.
// - Load request copies control word into comparator.
// - Both loads together are refused, error flagged.
// - Busy flag answers load requests as handshake.
// - Hit flags follow current comparator results.
// - Supply fault clears after short gone plus ack.
// - Faulty encoder frames raise frame fault flag.
// - Frame fault holds until cause gone plus ack.
// - Bad step count sets config fault; valid clears.
// - Heartbeat toggles per real read-in, isochronous only.
// - Down flag on decreasing position, wrap included.
// - Auxiliary pin level mirrored into status bit.
// - Ready only with good parameters while running.
// - Reduction n reads encoder every n-th cycle, isochronous only.
`timescale 1ns/1ns
`default_nettype none
`include "ssi_image_map.svh"
module image_device_end
    import ssi_image_pkg::*;
#(
    parameter int CYCLE_CLKS = `CYCLE_CLKS_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    ssi_image_if.device img,
    input wire logic [30:0] enc_value_i,
    input wire logic enc_frozen_i,
    input wire logic enc_frame_fault_i,
    input wire logic supply_short_i,
    input wire logic aux_input_pin_i,
    input wire logic iso_mode_i,
    input wire logic heartbeat_enable_i,
    input wire logic [5:0] reduction_i,
    input wire logic param_load_i,
    input wire logic [31:0] param_steps_i,
    input wire logic [31:0] param_steps_max_i,
    input wire logic run_i,
    output logic compare_one_hit_o,
    output logic compare_two_hit_o,
    output logic latch_ack_o,
    output logic ready_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam dev_state_t DEV_RESET = '{ld: LD_IDLE, default: '0};

    dev_state_t s_r;
    dev_state_t s_nxt;
    logic tick;
    logic read_in;
    logic req_one;
    logic req_two;
    logic fault_ack;
    logic [30:0] diff;
    logic [31:0] word_hi;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.fb_valid = 1'b0;
        read_in = 1'b0;
        diff = '0;
        word_hi = `WORD_RESET;
        req_one = img.ctl_hi[`CTL_LOAD_ONE_BIT];
        req_two = img.ctl_hi[`CTL_LOAD_TWO_BIT];
        fault_ack = img.ctl_hi[`CTL_FAULT_ACK_BIT];
        tick = (s_r.tick_cnt == cycle_cnt_t'(CYCLE_CLKS - 1));

        // The first stage feeds only the second one.
        s_nxt.aux_sync = {s_r.aux_sync[0], aux_input_pin_i};
        s_nxt.short_sync = {s_r.short_sync[0], supply_short_i};

        // Set wins over acknowledge, so a live cause is never lost.
        s_nxt.supply_short_fault = s_r.short_sync[1]
            | (s_r.supply_short_fault & ~fault_ack);
        s_nxt.encoder_frame_fault = enc_frame_fault_i
            | (s_r.encoder_frame_fault & ~fault_ack);

        if (param_load_i)
        begin
            s_nxt.params_seen = 1'b1;
            s_nxt.config_fault = (param_steps_i == 32'h0000_0000)
                || (param_steps_i > param_steps_max_i);
        end
        s_nxt.ready = s_r.params_seen & ~s_r.config_fault & run_i;
        s_nxt.latch_ack = img.ctl_hi[`CTL_LATCH_ACK_BIT];

        s_nxt.compare_one_hit = {1'b0, s_r.pos} >= s_r.cmp_one;
        s_nxt.compare_two_hit = {1'b0, s_r.pos} >= s_r.cmp_two;

        if (tick)
        begin
            s_nxt.tick_cnt = '0;
        end
        else
        begin
            s_nxt.tick_cnt = s_r.tick_cnt + cycle_cnt_t'(1);
        end

        if (tick)
        begin
            // Reduction only applies in isochronous mode.
            if (iso_mode_i && reduction_i > 6'h01)
            begin
                if (s_r.red_cnt == 6'h00)
                begin
                    read_in = 1'b1;
                    s_nxt.red_cnt = reduction_i - 6'h01;
                end
                else
                begin
                    s_nxt.red_cnt = s_r.red_cnt - 6'h01;
                end
            end
            else
            begin
                read_in = 1'b1;
                s_nxt.red_cnt = 6'h00;
            end

            if (read_in)
            begin
                // Modular difference keeps the sense across a wrap.
                diff = enc_value_i - s_r.pos;
                if (diff != 31'h0000_0000)
                begin
                    s_nxt.moving_up_flag = ~diff[30];
                    s_nxt.moving_down_flag = diff[30];
                end
                s_nxt.pos = enc_value_i;
                s_nxt.frozen = enc_frozen_i;
                if (iso_mode_i && heartbeat_enable_i)
                begin
                    s_nxt.heartbeat_toggle = ~s_r.heartbeat_toggle;
                end
            end
            if (!(iso_mode_i && heartbeat_enable_i))
            begin
                s_nxt.heartbeat_toggle = 1'b0;
            end

            // Load requests and the comparison value are sampled once per processing cycle.
            case (s_r.ld)
                LD_IDLE:
                begin
                    if (req_one && req_two)
                    begin
                        s_nxt.ld = LD_ERR;
                        s_nxt.load_error = 1'b1;
                    end
                    else if (req_one || req_two)
                    begin
                        if (req_one)
                        begin
                            s_nxt.cmp_one = img.ctl_lo;
                        end
                        else
                        begin
                            s_nxt.cmp_two = img.ctl_lo;
                        end
                        s_nxt.ld = LD_BUSY;
                        s_nxt.value_load_busy = 1'b1;
                    end
                end
                LD_BUSY:
                begin
                    if (!req_one && !req_two)
                    begin
                        s_nxt.ld = LD_IDLE;
                        s_nxt.value_load_busy = 1'b0;
                    end
                end
                LD_ERR:
                begin
                    if (!(req_one && req_two))
                    begin
                        s_nxt.ld = LD_IDLE;
                        s_nxt.load_error = 1'b0;
                    end
                end
                default:
                begin
                    s_nxt.ld = LD_IDLE;
                end
            endcase

            // Both words are built from registered state in one edge.
            word_hi[`FB_HEARTBEAT_BIT] = s_r.heartbeat_toggle;
            word_hi[`FB_READY_BIT] = s_r.ready;
            word_hi[`FB_CONFIG_FAULT_BIT] = s_r.config_fault;
            word_hi[`FB_FRAME_FAULT_BIT] = s_r.encoder_frame_fault;
            word_hi[`FB_SUPPLY_FAULT_BIT] = s_r.supply_short_fault;
            word_hi[`FB_INPUT_LEVEL_BIT] = s_r.aux_sync[1];
            word_hi[`FB_DOWN_BIT] = s_r.moving_down_flag;
            word_hi[`FB_UP_BIT] = s_r.moving_up_flag;
            word_hi[`FB_HIT_TWO_BIT] = s_r.compare_two_hit;
            word_hi[`FB_HIT_ONE_BIT] = s_r.compare_one_hit;
            word_hi[`FB_LOAD_ERROR_BIT] = s_r.load_error;
            word_hi[`FB_LOAD_BUSY_BIT] = s_r.value_load_busy;
            s_nxt.fb_hi = word_hi;
            s_nxt.fb_lo = {s_r.frozen, s_r.pos};
            s_nxt.fb_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_r <= DEV_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign img.fb_lo = s_r.fb_lo;
    assign img.fb_hi = s_r.fb_hi;
    assign img.fb_valid = s_r.fb_valid;
    assign compare_one_hit_o = s_r.compare_one_hit;
    assign compare_two_hit_o = s_r.compare_two_hit;
    assign latch_ack_o = s_r.latch_ack;
    assign ready_o = s_r.ready;

endmodule
`default_nettype wire

// [rtl/image_master_end.sv]
// Controller end of the encoder process image, run by software over APB.
// Assumes the device end shares sys_clk_i; APB comes from a same-clock
// master. The access phase always completes in its first cycle.
`timescale 1ns/1ns
`default_nettype none
`include "ssi_image_map.svh"
module image_master_end
    import ssi_image_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    ssi_image_if.master img,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mst_state_t s_r;
    mst_state_t s_nxt;
    logic wr_take;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        wr_take = psel_i & penable_i & s_r.pready & pwrite_i & ~s_r.pslverr;

        // Decode in the setup cycle so the answer leaves a flip-flop.
        if (psel_i && !penable_i)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = 1'b0;
            case (paddr_i)
                `REG_CMP_VALUE: s_nxt.prdata = s_r.stage_val;
                `REG_CONTROL: s_nxt.prdata = s_r.ctl_hi;
                `REG_FB_POSITION: s_nxt.prdata = s_r.fb_lo;
                `REG_FB_STATUS: s_nxt.prdata = s_r.fb_hi;
                `REG_FB_COUNT: s_nxt.prdata = {24'h00_0000, s_r.fb_cnt};
                default:
                begin
                    s_nxt.prdata = `WORD_RESET;
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        if (wr_take && paddr_i == `REG_CMP_VALUE)
        begin
            s_nxt.stage_val = pwdata_i;
        end
        // Value and request move together, so the device never sees a
        // request paired with a stale comparison value.
        if (wr_take && paddr_i == `REG_CONTROL)
        begin
            s_nxt.ctl_lo = s_r.stage_val;
            s_nxt.ctl_hi = pwdata_i & `CTL_USED_MASK;
        end

        if (img.fb_valid)
        begin
            s_nxt.fb_lo = img.fb_lo;
            s_nxt.fb_hi = img.fb_hi;
            s_nxt.fb_cnt = s_r.fb_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign img.ctl_lo = s_r.ctl_lo;
    assign img.ctl_hi = s_r.ctl_hi;
    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;

endmodule
`default_nettype wire

// [bench/ssi_image_props.sv]
// Concurrent checks on the process image between the two ends.
// Assumes plain interface signals plus the shared clock and reset.
`timescale 1ns/1ns
`default_nettype none
module ssi_image_props
#(
    parameter int CYCLE_CLKS = 16
)
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] fb_lo,
    input wire logic [31:0] fb_hi,
    input wire logic fb_valid,
    input wire logic [31:0] ctl_lo,
    input wire logic [31:0] ctl_hi
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [15:0] gap_r;
    logic [15:0] both_r;
    logic [15:0] idle_r;
    logic seen_r;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gap_r <= 16'h0000;
            both_r <= 16'h0000;
            idle_r <= 16'h0000;
            seen_r <= 1'h0;
        end
        else
        begin
            gap_r <= fb_valid ? 16'h0000 : gap_r + 16'h0001;
            both_r <= (ctl_hi[1:0] == 2'h3) ? both_r + 16'h0001 : 16'h0000;
            idle_r <= (ctl_hi[1:0] == 2'h0) ? idle_r + 16'h0001 : 16'h0000;
            seen_r <= seen_r | fb_valid;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_spare_zero: assert property (fb_hi[31:12] == 20'h00000)
        else $error("feedback spare bits not zero");
    chk_ctl_spare: assert property ((ctl_hi & ~32'h0000_00C3) == 0)
        else $error("control spare bits not zero");
    chk_fb_whole: assert property (!fb_valid |->
        $stable(fb_lo) && $stable(fb_hi))
        else $error("feedback word changed without strobe");
    chk_valid_pulse: assert property (fb_valid |=> !fb_valid [*8])
        else $error("feedback strobe too long");
    chk_valid_period: assert property (fb_valid && seen_r |->
        int'(gap_r) == CYCLE_CLKS - 1)
        else $error("feedback strobe period wrong");
    chk_both_refused: assert property (fb_valid &&
        int'(both_r) > 2 * CYCLE_CLKS + 4 |-> fb_hi[9] && !fb_hi[8])
        else $error("double load not refused");
    // The request was sampled one processing cycle before the busy flag
    // is published, and software may already have dropped it since.
    chk_busy_cause: assert property ($rose(fb_hi[8]) |->
        $past(ctl_hi[1:0], CYCLE_CLKS + 1) inside {2'h1, 2'h2})
        else $error("busy rose without single request");
    chk_busy_drop: assert property (fb_valid &&
        int'(idle_r) > 2 * CYCLE_CLKS + 4 |-> !fb_hi[8])
        else $error("busy held without request");
    chk_dir_excl: assert property (!(fb_hi[0] && fb_hi[1]))
        else $error("up and down both set");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench: both ends joined by the image interface,
// software traffic over APB, encoder inputs driven directly.
// Assumes one 25 MHz clock and a shortened processing cycle.
`timescale 1ns/1ns
`default_nettype none
`include "ssi_image_map.svh"
module tb_top;
    localparam int CYC = 16;
    logic sys_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, steps, smax;
    logic [30:0] enc;
    logic frozen, frame, short_pin, aux, iso, hb_en, pload, rerr, run;
    logic [5:0] red;
    logic hit1, hit2, latch, ready, hb, h1, h2;
    int num_errors = 0;
    int n_compared = 0;
    int n_fb = 0;

    ssi_image_if ssi_image_if_i();
    image_device_end #(.CYCLE_CLKS(CYC)) image_device_end_i
    (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .img(ssi_image_if_i),
        .enc_value_i(enc), .enc_frozen_i(frozen),
        .enc_frame_fault_i(frame), .supply_short_i(short_pin),
        .aux_input_pin_i(aux), .iso_mode_i(iso),
        .heartbeat_enable_i(hb_en), .reduction_i(red),
        .param_load_i(pload), .param_steps_i(steps),
        .param_steps_max_i(smax), .run_i(run),
        .compare_one_hit_o(hit1), .compare_two_hit_o(hit2),
        .latch_ack_o(latch), .ready_o(ready)
    );
    image_master_end image_master_end_i
    (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .img(ssi_image_if_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr)
    );
    ssi_image_props #(.CYCLE_CLKS(CYC)) ssi_image_props_i
    (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .fb_lo(ssi_image_if_i.fb_lo), .fb_hi(ssi_image_if_i.fb_hi),
        .fb_valid(ssi_image_if_i.fb_valid),
        .ctl_lo(ssi_image_if_i.ctl_lo), .ctl_hi(ssi_image_if_i.ctl_hi)
    );
    wire logic [31:0] fbh = ssi_image_if_i.fb_hi;
    // Independent tally of published feedback words.
    always @(posedge sys_clk_i)
        if (ssi_image_if_i.fb_valid)
            n_fb <= n_fb + 1;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic fbit(input string nm, input int b, input logic e);
        check(nm, {31'h0, e}, {31'h0, fbh[b]});
    endtask
    // Setup lasts one cycle; access is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'h1;
        @(posedge sys_clk_i iff pready);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk_i);
    endtask
    // Fault flags lag a whole cycle, so callers checking them wait three or more.
    task automatic wfb(input int n);
        repeat (n) @(posedge sys_clk_i iff ssi_image_if_i.fb_valid);
    endtask
    task automatic params(input logic [31:0] v);
        steps <= v;
        pload <= 1'h1;
        @(posedge sys_clk_i);
        pload <= 1'h0;
        wfb(3);
    endtask
    task automatic conclude;
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        sys_clk_i = 1'h0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        conclude();
    end
    initial
    begin
        {nrst_i, psel, penable, pwrite, frozen, frame} = 6'h00;
        {short_pin, aux, iso, hb_en, pload} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        enc = 31'h0000_0000;
        red = 6'h01;
        steps = 32'h0000_0064;
        smax = 32'h0000_03E8;
        run = 1'h1;
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'h1;
        @(posedge sys_clk_i);
        params(32'h0000_0064);
        fbit("ready", `FB_READY_BIT, 1'h1);
        check("ready_o", 32'h1, {31'h0, ready});
        params(32'h0000_0000);
        fbit("cfg_bad", `FB_CONFIG_FAULT_BIT, 1'h1);
        fbit("not_ready", `FB_READY_BIT, 1'h0);
        smax <= 32'h0000_0063;
        params(32'h0000_0064);
        fbit("cfg_over", `FB_CONFIG_FAULT_BIT, 1'h1);
        smax <= 32'h0000_03E8;
        params(32'h0000_03E8);
        fbit("cfg_good", `FB_CONFIG_FAULT_BIT, 1'h0);
        enc <= 31'h0000_0100;
        wfb(3);
        check("position", 32'h0000_0100, ssi_image_if_i.fb_lo);
        enc <= 31'h0000_0050;
        frozen <= 1'h1;
        wfb(3);
        check("frozen", 32'h8000_0050, ssi_image_if_i.fb_lo);
        fbit("down", `FB_DOWN_BIT, 1'h1);
        frozen <= 1'h0;
        enc <= 31'h0000_00C8;
        aux <= 1'h1;
        wfb(3);
        fbit("up", `FB_UP_BIT, 1'h1);
        fbit("aux", `FB_INPUT_LEVEL_BIT, 1'h1);
        apb(1'h0, `REG_FB_POSITION, 32'h0);
        check("apb_pos", 32'h0000_00C8, rd);
        apb(1'h0, 8'h20, 32'h0);
        check("unmapped", 32'h1, {31'h0, rerr});
        apb(1'h1, `REG_CMP_VALUE, 32'h0000_00D0);
        apb(1'h1, `REG_CONTROL, 32'h0000_0001);
        check("ctl_lo", 32'h0000_00D0, ssi_image_if_i.ctl_lo);
        check("ctl_hi", 32'h0000_0001, ssi_image_if_i.ctl_hi);
        wfb(3);
        fbit("busy", `FB_LOAD_BUSY_BIT, 1'h1);
        check("hit1", 32'h0, {31'h0, hit1});
        fbit("hit1_fb", `FB_HIT_ONE_BIT, 1'h0);
        apb(1'h1, `REG_CONTROL, 32'h0);
        wfb(3);
        fbit("idle", `FB_LOAD_BUSY_BIT, 1'h0);
        apb(1'h1, `REG_CMP_VALUE, 32'h0000_012C);
        apb(1'h1, `REG_CONTROL, 32'h0000_003E);
        check("ctl_mask", 32'h0000_0002, ssi_image_if_i.ctl_hi);
        apb(1'h0, `REG_CONTROL, 32'h0);
        check("ctl_read", 32'h0000_0002, rd);
        apb(1'h0, `REG_CMP_VALUE, 32'h0);
        check("cmp_read", 32'h0000_012C, rd);
        wfb(3);
        check("hit2_low", 32'h0, {31'h0, hit2});
        apb(1'h1, `REG_CONTROL, 32'h0);
        enc <= 31'h0000_012C;
        wfb(3);
        check("hit2_eq", 32'h1, {31'h0, hit2});
        fbit("hit2_fb", `FB_HIT_TWO_BIT, 1'h1);
        check("hit1_kept", 32'h1, {31'h0, hit1});
        apb(1'h1, `REG_CONTROL, 32'h0000_0003);
        wfb(4);
        fbit("load_err", `FB_LOAD_ERROR_BIT, 1'h1);
        apb(1'h1, `REG_CONTROL, 32'h0);
        short_pin <= 1'h1;
        frame <= 1'h1;
        wfb(4);
        fbit("short", `FB_SUPPLY_FAULT_BIT, 1'h1);
        fbit("frame", `FB_FRAME_FAULT_BIT, 1'h1);
        fbit("ld_err_clr", `FB_LOAD_ERROR_BIT, 1'h0);
        short_pin <= 1'h0;
        frame <= 1'h0;
        wfb(4);
        fbit("short_held", `FB_SUPPLY_FAULT_BIT, 1'h1);
        fbit("frame_held", `FB_FRAME_FAULT_BIT, 1'h1);
        apb(1'h1, `REG_CONTROL, 32'h0000_0080);
        wfb(4);
        fbit("short_clr", `FB_SUPPLY_FAULT_BIT, 1'h0);
        fbit("frame_clr", `FB_FRAME_FAULT_BIT, 1'h0);
        apb(1'h1, `REG_CONTROL, 32'h0000_0040);
        wfb(1);
        check("latch_ack", 32'h1, {31'h0, latch});
        apb(1'h0, `REG_FB_COUNT, 32'h0);
        check("fb_count", {24'h00_0000, n_fb[7:0]}, rd);
        run <= 1'h0;
        wfb(3);
        fbit("stopped", `FB_READY_BIT, 1'h0);
        check("ready_off", 32'h0, {31'h0, ready});
        run <= 1'h1;
        iso <= 1'h1;
        hb_en <= 1'h1;
        wfb(3);
        hb = fbh[`FB_HEARTBEAT_BIT];
        wfb(1);
        fbit("hb_toggle", `FB_HEARTBEAT_BIT, ~hb);
        red <= 6'h02;
        wfb(3);
        hb = fbh[`FB_HEARTBEAT_BIT];
        wfb(1);
        h1 = fbh[`FB_HEARTBEAT_BIT];
        wfb(1);
        h2 = fbh[`FB_HEARTBEAT_BIT];
        check("hb_reduced", 32'h1, 32'(hb ^ h1) + 32'(h1 ^ h2));
        conclude();
    end
endmodule
`default_nettype wire
